// ===== logic/t16_consts.svh
`ifndef T16_CONSTS_SVH
`define T16_CONSTS_SVH
// Byte locations on the 8-bit data bus
`define T16_ADDR_CNT_LO   4'h0
`define T16_ADDR_CNT_HI   4'h1
`define T16_ADDR_CMPA_LO  4'h2
`define T16_ADDR_CMPA_HI  4'h3
`define T16_ADDR_CMPB_LO  4'h4
`define T16_ADDR_CMPB_HI  4'h5
`define T16_ADDR_CAP_LO   4'h6
`define T16_ADDR_CAP_HI   4'h7
`define T16_ADDR_CTRL_A   4'h8
`define T16_ADDR_CTRL_B   4'h9
`define T16_ADDR_FLAGS    4'ha
`define T16_ADDR_MASK     4'hb
`define T16_ADDR_HI_BIT   0
// Counter landmarks and fixed tops
`define T16_BOTTOM        16'h0000
`define T16_MAX           16'hffff
`define T16_TOP_8BIT      16'h00ff
`define T16_TOP_9BIT      16'h01ff
`define T16_TOP_10BIT     16'h03ff
// Control fields
`define T16_CTRLA_TOP_MSB 2
`define T16_CTRLA_TOP_LSB 0
`define T16_CTRLA_PWM     3
`define T16_CTRLB_CS_MSB  2
`define T16_CTRLB_CS_LSB  0
`define T16_CTRLB_SRC     5
`define T16_CTRLB_EDGE    6
`define T16_CTRLB_FILT    7
// Flag and mask bit positions
`define T16_FLAG_OVF      0
`define T16_FLAG_MA       1
`define T16_FLAG_MB       2
`define T16_FLAG_CAP      3
`define T16_FLAG_W        4
// Prescaler masks
`define T16_PRE_DIV8      10'h007
`define T16_PRE_DIV64     10'h03f
`define T16_PRE_DIV256    10'h0ff
`define T16_PRE_DIV1024   10'h3ff
// Noise filter sample count
`define T16_FILT_LEN      4
`define T16_FILT_ONES     4'hf
`define T16_FILT_ZEROS    4'h0
// Reset values
`define T16_RST_BYTE      8'h00
`define T16_RST_WORD      16'h0000
`define T16_RST_PRE       10'h000
`endif

// ===== logic/t16_pkg.sv
`default_nettype none
package t16_pkg;
   typedef enum logic [2:0] {
      T16_CS_STOP    = 3'h0,
      T16_CS_DIV1    = 3'h1,
      T16_CS_DIV8    = 3'h2,
      T16_CS_DIV64   = 3'h3,
      T16_CS_DIV256  = 3'h4,
      T16_CS_DIV1024 = 3'h5,
      T16_CS_EXT_FALL = 3'h6,
      T16_CS_EXT_RISE = 3'h7
   } t16_clk_sel_t;
   typedef enum logic [2:0] {
      T16_TOP_MAX  = 3'h0,
      T16_TOP_8    = 3'h1,
      T16_TOP_9    = 3'h2,
      T16_TOP_10   = 3'h3,
      T16_TOP_CMPA = 3'h4,
      T16_TOP_CAP  = 3'h5
   } t16_top_sel_t;
   typedef enum logic [1:0] {
      T16_IDLE   = 2'b00,
      T16_FIRST  = 2'b01,
      T16_SECOND = 2'b11,
      T16_LAST   = 2'b10
   } t16_state_t;
endpackage
`default_nettype wire

// ===== logic/t16_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface t16_bus_if;
   logic [3:0] addr;
   logic       wr_en;
   logic       rd_en;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport dev  (input addr, input wr_en, input rd_en, input wdata, output rdata);
   modport host (output addr, output wr_en, output rd_en, output wdata, input rdata);
endinterface
`default_nettype wire

// ===== logic/t16_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "t16_consts.svh"
module t16_host
   import t16_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   t16_bus_if.host          bus,
   input  wire logic        cmd_valid_i,
   input  wire logic        cmd_write_i,
   input  wire logic        cmd_wide_i,
   input  wire logic [3:0]  cmd_addr_i,
   input  wire logic [15:0] cmd_wdata_i,
   output logic             cmd_ready_o,
   output logic             rsp_valid_o,
   output logic [15:0]      rsp_data_o
);
   t16_state_t  state_reg;
   logic        write_reg;
   logic        wide_reg;
   logic [3:0]  addr_reg;
   logic [7:0]  lo_reg;
   logic [7:0]  wlo_reg;
   logic [3:0]  bus_addr_reg;
   logic        bus_wr_reg;
   logic        bus_rd_reg;
   logic [7:0]  bus_wdata_reg;
   logic        start;

   assign start       = (state_reg == T16_IDLE) && cmd_valid_i;
   assign bus.addr    = bus_addr_reg;
   assign bus.wr_en   = bus_wr_reg;
   assign bus.rd_en   = bus_rd_reg;
   assign bus.wdata   = bus_wdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer; no new command until the one or two bytes of the current one are done
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state_reg <= T16_IDLE;
      end else begin
         unique case (state_reg)
            T16_IDLE:   if (cmd_valid_i) state_reg <= T16_FIRST;
            T16_FIRST:  state_reg <= wide_reg ? T16_SECOND : T16_LAST;
            T16_SECOND: state_reg <= T16_LAST;
            T16_LAST:   state_reg <= T16_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         write_reg <= 1'b0;
         wide_reg  <= 1'b0;
         addr_reg  <= 4'h0;
         wlo_reg   <= `T16_RST_BYTE;
      end else if (start) begin
         write_reg <= cmd_write_i;
         wide_reg  <= cmd_wide_i;
         addr_reg  <= cmd_addr_i;
         wlo_reg   <= cmd_wdata_i[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Byte strobes
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         bus_addr_reg  <= 4'h0;
         bus_wr_reg    <= 1'b0;
         bus_rd_reg    <= 1'b0;
         bus_wdata_reg <= `T16_RST_BYTE;
      end else if (start) begin
         bus_wr_reg <= cmd_write_i;
         bus_rd_reg <= !cmd_write_i;
         if (cmd_wide_i && cmd_write_i) begin
            bus_addr_reg  <= cmd_addr_i | 4'h1;
            bus_wdata_reg <= cmd_wdata_i[15:8];
         end else begin
            bus_addr_reg  <= cmd_addr_i;
            bus_wdata_reg <= cmd_wdata_i[7:0];
         end
      end else if (state_reg == T16_FIRST && wide_reg) begin
         if (write_reg) begin
            bus_addr_reg  <= addr_reg;
            bus_wdata_reg <= wlo_reg;
         end else begin
            bus_addr_reg <= addr_reg | 4'h1;
         end
      end else begin
         bus_wr_reg <= 1'b0;
         bus_rd_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Answer
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         lo_reg      <= `T16_RST_BYTE;
         rsp_valid_o <= 1'b0;
         rsp_data_o  <= `T16_RST_WORD;
         cmd_ready_o <= 1'b0;
      end else begin
         cmd_ready_o <= (state_reg == T16_LAST) ||
                        (state_reg == T16_IDLE && !cmd_valid_i);
         rsp_valid_o <= (state_reg == T16_LAST);
         if (state_reg == T16_SECOND && !write_reg) begin
            lo_reg <= bus.rdata;
         end
         if (state_reg == T16_LAST) begin
            if (write_reg) begin
               rsp_data_o <= `T16_RST_WORD;
            end else if (wide_reg) begin
               rsp_data_o <= {bus.rdata, lo_reg};
            end else begin
               rsp_data_o <= {`T16_RST_BYTE, bus.rdata};
            end
         end
      end
   end
endmodule // t16_host
`default_nettype wire

// ===== logic/t16_dev.sv
`timescale 1ns/1ps
`default_nettype none
`include "t16_consts.svh"
module t16_dev
   import t16_pkg::*;
(
   input  wire logic ref_clk_i,
   input  wire logic rst_n_i,
   t16_bus_if.dev    bus,
   input  wire logic ext_count_pin_i,
   input  wire logic capture_input_pin_i,
   input  wire logic comparator_i,
   input  wire logic timer_power_off_bit_i,
   output logic      wave_a_o,
   output logic      wave_b_o,
   output logic      irq_o,
   output logic      bottom_o,
   output logic      max_o
);
   logic [15:0]  counter_value, capture_value, top_val;
   logic [15:0]  cmp_a_buf, cmp_b_buf, compare_a_value, compare_b_value;
   logic [7:0]   timer_control_a, timer_control_b, temp_reg, rdata_reg;
   logic [3:0]   timer_flag_reg, timer_mask_reg, filt_reg;
   logic [9:0]   pre_reg;
   logic [2:0]   ext_sync_reg;
   logic [1:0]   pin_sync_reg, cmp_sync_reg;
   logic         cap_lvl_reg, cap_prev_reg, timer_tick, run, wr, rd, pwm;
   logic         at_top, match_a, match_b, cap_raw, cap_evt;
   t16_clk_sel_t clk_sel;
   t16_top_sel_t top_sel;
   function automatic logic pre_hit(input logic [9:0] pre, input logic [9:0] mask);
      pre_hit = ((pre & mask) == mask);
   endfunction
   function automatic logic is_addr(input logic [3:0] a, input logic [3:0] b);
      is_addr = (a == b);
   endfunction
   assign run     = !timer_power_off_bit_i;
   assign wr      = bus.wr_en && run;
   assign rd      = bus.rd_en && run;
   assign clk_sel = t16_clk_sel_t'(timer_control_b[`T16_CTRLB_CS_MSB:`T16_CTRLB_CS_LSB]);
   assign top_sel = t16_top_sel_t'(timer_control_a[`T16_CTRLA_TOP_MSB:`T16_CTRLA_TOP_LSB]);
   assign pwm     = timer_control_a[`T16_CTRLA_PWM];
   assign bus.rdata = rdata_reg;
   ////////////////////////////////////////////////////////////////////////////
   // Clock select
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         pre_reg      <= `T16_RST_PRE;
         ext_sync_reg <= 3'h0;
      end else begin
         pre_reg      <= run ? pre_reg + 10'h001 : `T16_RST_PRE;
         ext_sync_reg <= {ext_sync_reg[1:0], ext_count_pin_i};
      end
   end
   always_comb begin
      unique case (clk_sel)
         T16_CS_STOP:     timer_tick = 1'b0;
         T16_CS_DIV1:     timer_tick = 1'b1;
         T16_CS_DIV8:     timer_tick = pre_hit(pre_reg, `T16_PRE_DIV8);
         T16_CS_DIV64:    timer_tick = pre_hit(pre_reg, `T16_PRE_DIV64);
         T16_CS_DIV256:   timer_tick = pre_hit(pre_reg, `T16_PRE_DIV256);
         T16_CS_DIV1024:  timer_tick = pre_hit(pre_reg, `T16_PRE_DIV1024);
         T16_CS_EXT_FALL: timer_tick = ext_sync_reg[2] && !ext_sync_reg[1];
         T16_CS_EXT_RISE: timer_tick = !ext_sync_reg[2] && ext_sync_reg[1];
      endcase
      timer_tick = timer_tick && run;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Top and compare
   always_comb begin
      unique case (top_sel)
         T16_TOP_8:    top_val = `T16_TOP_8BIT;
         T16_TOP_9:    top_val = `T16_TOP_9BIT;
         T16_TOP_10:   top_val = `T16_TOP_10BIT;
         T16_TOP_CMPA: top_val = compare_a_value;
         T16_TOP_CAP:  top_val = capture_value;
         default:      top_val = `T16_MAX;
      endcase
   end
   assign at_top  = (counter_value == top_val);
   assign match_a = timer_tick && (counter_value == compare_a_value);
   assign match_b = timer_tick && (counter_value == compare_b_value);
   ////////////////////////////////////////////////////////////////////////////
   // Counter
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         counter_value <= `T16_RST_WORD;
      end else if (wr && is_addr(bus.addr, `T16_ADDR_CNT_LO)) begin
         counter_value <= {temp_reg, bus.wdata};
      end else if (timer_tick) begin
         counter_value <= at_top ? `T16_BOTTOM : counter_value + 16'h0001;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Compare buffers, loaded at top in PWM
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         cmp_a_buf       <= `T16_RST_WORD;
         cmp_b_buf       <= `T16_RST_WORD;
         compare_a_value <= `T16_RST_WORD;
         compare_b_value <= `T16_RST_WORD;
      end else begin
         if (wr && is_addr(bus.addr, `T16_ADDR_CMPA_LO)) begin
            cmp_a_buf <= {temp_reg, bus.wdata};
         end
         if (wr && is_addr(bus.addr, `T16_ADDR_CMPB_LO)) begin
            cmp_b_buf <= {temp_reg, bus.wdata};
         end
         if (!pwm || (timer_tick && at_top)) begin
            compare_a_value <= cmp_a_buf;
            compare_b_value <= cmp_b_buf;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Capture input, synchroniser and filter
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         pin_sync_reg <= 2'h0;
         cmp_sync_reg <= 2'h0;
         filt_reg     <= `T16_FILT_ZEROS;
         cap_lvl_reg  <= 1'b0;
         cap_prev_reg <= 1'b0;
      end else begin
         pin_sync_reg <= {pin_sync_reg[0], capture_input_pin_i};
         cmp_sync_reg <= {cmp_sync_reg[0], comparator_i};
         filt_reg     <= {filt_reg[`T16_FILT_LEN-2:0], cap_raw};
         if (!timer_control_b[`T16_CTRLB_FILT]) begin
            cap_lvl_reg <= cap_raw;
         end else if (filt_reg == `T16_FILT_ONES) begin
            cap_lvl_reg <= 1'b1;
         end else if (filt_reg == `T16_FILT_ZEROS) begin
            cap_lvl_reg <= 1'b0;
         end
         cap_prev_reg <= cap_lvl_reg;
      end
   end
   assign cap_raw = timer_control_b[`T16_CTRLB_SRC] ? cmp_sync_reg[1] : pin_sync_reg[1];
   assign cap_evt = run && (cap_lvl_reg != cap_prev_reg) &&
                    (cap_lvl_reg == timer_control_b[`T16_CTRLB_EDGE]);
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         capture_value <= `T16_RST_WORD;
      end else if (cap_evt && top_sel != T16_TOP_CAP) begin
         capture_value <= counter_value;
      end else if (wr && is_addr(bus.addr, `T16_ADDR_CAP_LO)) begin
         capture_value <= {temp_reg, bus.wdata};
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Shared high-byte latch
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         temp_reg <= `T16_RST_BYTE;
      end else if (wr && (is_addr(bus.addr, `T16_ADDR_CNT_HI) ||
                          is_addr(bus.addr, `T16_ADDR_CMPA_HI) ||
                          is_addr(bus.addr, `T16_ADDR_CMPB_HI) ||
                          is_addr(bus.addr, `T16_ADDR_CAP_HI))) begin
         temp_reg <= bus.wdata;
      end else if (rd && is_addr(bus.addr, `T16_ADDR_CNT_LO)) begin
         temp_reg <= counter_value[15:8];
      end else if (rd && is_addr(bus.addr, `T16_ADDR_CAP_LO)) begin
         temp_reg <= capture_value[15:8];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Control, flags and mask
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         timer_control_a <= `T16_RST_BYTE;
         timer_control_b <= `T16_RST_BYTE;
         timer_mask_reg  <= 4'h0;
      end else begin
         if (wr && is_addr(bus.addr, `T16_ADDR_CTRL_A)) timer_control_a <= bus.wdata;
         if (wr && is_addr(bus.addr, `T16_ADDR_CTRL_B)) timer_control_b <= bus.wdata;
         if (wr && is_addr(bus.addr, `T16_ADDR_MASK)) begin
            timer_mask_reg <= bus.wdata[`T16_FLAG_W-1:0];
         end
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         timer_flag_reg <= 4'h0;
      end else begin
         timer_flag_reg <= (timer_flag_reg &
                            ~((wr && is_addr(bus.addr, `T16_ADDR_FLAGS)) ?
                              bus.wdata[`T16_FLAG_W-1:0] : 4'h0)) |
                           {cap_evt && top_sel != T16_TOP_CAP,
                            match_b,
                            match_a,
                            timer_tick && at_top};
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         rdata_reg <= `T16_RST_BYTE;
      end else if (rd) begin
         unique case (bus.addr)
            `T16_ADDR_CNT_LO:  rdata_reg <= counter_value[7:0];
            `T16_ADDR_CNT_HI:  rdata_reg <= temp_reg;
            `T16_ADDR_CMPA_LO: rdata_reg <= cmp_a_buf[7:0];
            `T16_ADDR_CMPA_HI: rdata_reg <= cmp_a_buf[15:8];
            `T16_ADDR_CMPB_LO: rdata_reg <= cmp_b_buf[7:0];
            `T16_ADDR_CMPB_HI: rdata_reg <= cmp_b_buf[15:8];
            `T16_ADDR_CAP_LO:  rdata_reg <= capture_value[7:0];
            `T16_ADDR_CAP_HI:  rdata_reg <= temp_reg;
            `T16_ADDR_CTRL_A:  rdata_reg <= timer_control_a;
            `T16_ADDR_CTRL_B:  rdata_reg <= timer_control_b;
            `T16_ADDR_FLAGS:   rdata_reg <= {4'h0, timer_flag_reg};
            `T16_ADDR_MASK:    rdata_reg <= {4'h0, timer_mask_reg};
            default:           rdata_reg <= `T16_RST_BYTE;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Waveform and status outputs
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         wave_a_o <= 1'b0;
         wave_b_o <= 1'b0;
         irq_o    <= 1'b0;
         bottom_o <= 1'b0;
         max_o    <= 1'b0;
      end else begin
         if (pwm && top_sel == T16_TOP_CMPA) begin
            wave_a_o <= 1'b0;
         end else if (pwm) begin
            if (match_a) wave_a_o <= 1'b0;
            else if (timer_tick && at_top) wave_a_o <= 1'b1;
         end else if (match_a) begin
            wave_a_o <= !wave_a_o;
         end
         if (pwm) begin
            if (match_b) wave_b_o <= 1'b0;
            else if (timer_tick && at_top) wave_b_o <= 1'b1;
         end else if (match_b) begin
            wave_b_o <= !wave_b_o;
         end
         irq_o    <= |(timer_flag_reg & timer_mask_reg);
         bottom_o <= (counter_value == `T16_BOTTOM);
         max_o    <= (counter_value == `T16_MAX);
      end
   end
endmodule // t16_dev
`default_nettype wire

// ===== testbench/t16_bus_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module t16_bus_asserts (
   input wire logic       ref_clk_i,
   input wire logic       rst_n_i,
   input wire logic [3:0] addr,
   input wire logic       wr_en,
   input wire logic       rd_en,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata
);
   logic [7:0]  latch_reg;
   logic [15:0] cmpa_reg;
   logic [15:0] cmpb_reg;
   logic        lat_ok_reg;
   logic        a_ok_reg;
   logic        b_ok_reg;
   wire         word_loc = (addr[3] == 1'b0);

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   ////////////////////////////////////////////////////////////////////////////
   // Shadow of the shared latch and both compare words
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         latch_reg  <= 8'h00;
         cmpa_reg   <= 16'h0000;
         cmpb_reg   <= 16'h0000;
         lat_ok_reg <= 1'b1;
         a_ok_reg   <= 1'b1;
         b_ok_reg   <= 1'b1;
      end else begin
         if (wr_en && word_loc && addr[0]) begin
            latch_reg  <= wdata;
            lat_ok_reg <= 1'b1;
         end
         if (rd_en && (addr == 4'h0 || addr == 4'h6)) begin
            lat_ok_reg <= 1'b0;
         end
         if (wr_en && addr == 4'h2) begin
            cmpa_reg <= {latch_reg, wdata};
            a_ok_reg <= lat_ok_reg;
         end
         if (wr_en && addr == 4'h4) begin
            cmpb_reg <= {latch_reg, wdata};
            b_ok_reg <= lat_ok_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   AST_ONE_STROBE: assert property (!(wr_en && rd_en))
      else $error("write and read strobes together");
   AST_HI_WRITE_PAIRS: assert property ($rose(wr_en) && word_loc && addr[0]
      |=> !wr_en || addr == ($past(addr) & 4'he)) else $error("high write not paired");
   AST_LO_READ_LEADS: assert property (rd_en && $past(rd_en) && word_loc
      |-> addr[0] && $past(addr) == {addr[3:1], 1'b0}) else $error("read pair out of order");
   AST_PAIR_THEN_IDLE: assert property ((wr_en && $past(wr_en)) || (rd_en && $past(rd_en))
      |=> !wr_en && !rd_en) else $error("byte pair not closed");
   AST_RDATA_HOLDS: assert property (!$past(rd_en) |-> $stable(rdata))
      else $error("read data moved without a read");
   AST_CMPA_READ: assert property (rd_en && addr[3:1] == 3'h1 && a_ok_reg
      |=> rdata == ($past(addr[0]) ? cmpa_reg[15:8] : cmpa_reg[7:0])) else $error("compare A read");
   AST_CMPB_READ: assert property (rd_en && addr[3:1] == 3'h2 && b_ok_reg
      |=> rdata == ($past(addr[0]) ? cmpb_reg[15:8] : cmpb_reg[7:0])) else $error("compare B read");
   AST_HI_FROM_LATCH: assert property (rd_en && (addr == 4'h1 || addr == 4'h7) && lat_ok_reg
      |=> rdata == latch_reg) else $error("high location not the latch");

   COV_WRITE_PAIR: cover property (wr_en && $past(wr_en));
   COV_READ_PAIR: cover property (rd_en && $past(rd_en));
   COV_LATCH_READ: cover property (rd_en && addr == 4'h7 && lat_ok_reg);
endmodule // t16_bus_asserts
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        ref_clk_i;
   logic        rst_n_i = 1'b0;
   logic        cmd_valid_i = 1'b0;
   logic        cmd_write_i = 1'b0;
   logic        cmd_wide_i = 1'b0;
   logic [3:0]  cmd_addr_i = 4'h0;
   logic [15:0] cmd_wdata_i = 16'h0000;
   logic        ext_count_pin_i = 1'b0;
   logic        capture_input_pin_i = 1'b0;
   logic        timer_power_off_bit_i = 1'b0;
   logic        comparator_i = 1'b0;
   logic        cmd_ready_o, rsp_valid_o, wave_a_o, wave_b_o, irq_o, bottom_o, max_o;
   logic [15:0] rsp_data_o;
   int          err_total = 0;
   int          check_count = 0;

   t16_bus_if bus ();
   t16_host u_t16_host (.ref_clk_i, .rst_n_i, .bus, .cmd_valid_i, .cmd_write_i, .cmd_wide_i,
      .cmd_addr_i, .cmd_wdata_i, .cmd_ready_o, .rsp_valid_o, .rsp_data_o);
   t16_dev u_t16_dev (.ref_clk_i, .rst_n_i, .bus, .ext_count_pin_i, .capture_input_pin_i,
      .comparator_i, .timer_power_off_bit_i, .wave_a_o, .wave_b_o, .irq_o, .bottom_o, .max_o);
   t16_bus_asserts chk_bus (.ref_clk_i, .rst_n_i, .addr(bus.addr), .wr_en(bus.wr_en),
      .rd_en(bus.rd_en), .wdata(bus.wdata), .rdata(bus.rdata));

   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic cmd(input logic w, input logic wide, input logic [3:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(negedge ref_clk_i);
      chk({15'h0000, cmd_ready_o}, 16'h0001);
      cmd_valid_i = 1'b1;
      cmd_write_i = w;
      cmd_wide_i = wide;
      cmd_addr_i = a;
      cmd_wdata_i = d;
      @(negedge ref_clk_i);
      cmd_valid_i = 1'b0;
      chk({15'h0000, cmd_ready_o}, 16'h0000);
      while (rsp_valid_o !== 1'b1 && n < 20) begin
         @(negedge ref_clk_i);
         n++;
      end
      if (n == 20) begin
         err_total++;
         $display("Error at %0t: no response", $time);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic wide);
      cmd(1'b1, wide, a, d);
   endtask

   task automatic rd(input logic [3:0] a, input logic wide, input logic [15:0] exp);
      cmd(1'b0, wide, a, 16'h0000);
      chk(rsp_data_o, exp);
   endtask

   task automatic wait_for(input int sel);
      logic [2:0] v;
      int n;
      v = 3'h0;
      n = 0;
      while (n < 40 && v[sel] !== 1'b1) begin
         @(negedge ref_clk_i);
         v = {irq_o, bottom_o, max_o};
         n++;
      end
      chk({15'h0000, v[sel]}, 16'h0001);
   endtask

   task automatic ticks(input int k);
      repeat (k) @(negedge ref_clk_i);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rd(4'h8, 1'b0, 16'h0000);
      rd(4'ha, 1'b0, 16'h0000);
      wr(4'h8, 16'h005a, 1'b0);
      rd(4'h8, 1'b0, 16'h005a);
      wr(4'h8, 16'h0000, 1'b0);
      rd(4'hc, 1'b0, 16'h0000);
      wr(4'h0, 16'h01ff, 1'b1);
      rd(4'h0, 1'b1, 16'h01ff);
      rd(4'h1, 1'b0, 16'h0001);
      $display("test regs done");
   endtask

   task automatic t_latch;
      wr(4'h2, 16'ha55a, 1'b1);
      wr(4'h3, 16'h0066, 1'b0);
      rd(4'h2, 1'b1, 16'ha55a);
      rd(4'h7, 1'b0, 16'h0066);
      wr(4'h4, 16'h0022, 1'b0);
      rd(4'h4, 1'b1, 16'h6622);
      $display("test latch done");
   endtask

   task automatic t_count;
      wr(4'h0, 16'hfff0, 1'b1);
      wr(4'h4, 16'hfff8, 1'b1);
      wr(4'hb, 16'h0005, 1'b0);
      wr(4'h9, 16'h0001, 1'b0);
      wait_for(0);
      wait_for(1);
      wait_for(2);
      wr(4'h9, 16'h0000, 1'b0);
      rd(4'ha, 1'b0, 16'h0005);
      chk({15'h0000, wave_b_o}, 16'h0001);
      wr(4'ha, 16'h0005, 1'b0);
      rd(4'ha, 1'b0, 16'h0000);
      chk({15'h0000, irq_o}, 16'h0000);
      $display("test count done");
   endtask

   task automatic t_power;
      wr(4'h0, 16'h0100, 1'b1);
      wr(4'h9, 16'h0001, 1'b0);
      timer_power_off_bit_i = 1'b1;
      ticks(50);
      timer_power_off_bit_i = 1'b0;
      wr(4'h9, 16'h0000, 1'b0);
      cmd(1'b0, 1'b1, 4'h0, 16'h0000);
      check_count++;
      if ($isunknown(rsp_data_o) ||
          rsp_data_o <= 16'h0100 || rsp_data_o >= 16'h0110) begin
         err_total++;
         $display("Error at %0t: counter %h ran while off", $time, rsp_data_o);
      end
      $display("test power done");
   endtask

   task automatic t_ext;
      wr(4'h0, 16'h0000, 1'b1);
      wr(4'h9, 16'h0007, 1'b0);
      repeat (5) begin
         ext_count_pin_i = 1'b1;
         ticks(4);
         ext_count_pin_i = 1'b0;
         ticks(4);
      end
      rd(4'h0, 1'b1, 16'h0005);
      wr(4'h9, 16'h00c7, 1'b0);
      capture_input_pin_i = 1'b1;
      ticks(1);
      capture_input_pin_i = 1'b0;
      ticks(12);
      rd(4'ha, 1'b0, 16'h0000);
      wr(4'h9, 16'h0047, 1'b0);
      capture_input_pin_i = 1'b1;
      ticks(10);
      rd(4'ha, 1'b0, 16'h0008);
      rd(4'h6, 1'b1, 16'h0005);
      wr(4'ha, 16'h0008, 1'b0);
      wr(4'h9, 16'h0067, 1'b0);
      comparator_i = 1'b1;
      ticks(10);
      rd(4'ha, 1'b0, 16'h0008);
      $display("test ext done");
   endtask

   task automatic t_pwm;
      int   a_on;
      int   rise;
      int   fall;
      logic prev;
      a_on = 0;
      rise = 0;
      fall = 0;
      wr(4'h2, 16'h0010, 1'b1);
      wr(4'h4, 16'h0008, 1'b1);
      wr(4'h0, 16'h0000, 1'b1);
      wr(4'h8, 16'h000c, 1'b0);
      wr(4'h9, 16'h0001, 1'b0);
      prev = wave_b_o;
      repeat (40) begin
         @(negedge ref_clk_i);
         if (wave_a_o !== 1'b0) a_on++;
         if (wave_b_o === 1'b1 && prev === 1'b0) rise++;
         if (wave_b_o === 1'b0 && prev === 1'b1) fall++;
         prev = wave_b_o;
      end
      chk(16'(a_on), 16'h0000);
      chk({15'h0000, rise > 0 && fall > 0}, 16'h0001);
      wr(4'h9, 16'h0000, 1'b0);
      wr(4'h8, 16'h0000, 1'b0);
      $display("test pwm done");
   endtask

   task automatic test_done;
      $display("Checks %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      ticks(2);
      rst_n_i = 1'b1;
      t_regs;
      t_latch;
      t_count;
      t_power;
      t_ext;
      t_pwm;
      test_done;
   end

   initial begin
      repeat (5000) @(posedge ref_clk_i);
      err_total++;
      test_done;
   end
endmodule // testbench
`default_nettype wire
